// ===== hdl/bl_pkg.sv
// constants shared by the backlight brightness control block
// assumes a 20 MHz system clock and register writes from an i2c target
package bl_pkg;
	localparam logic [7:0] ADDR_CFG1     = 8'h02;
	localparam logic [7:0] ADDR_CFG2     = 8'h03;
	localparam logic [7:0] ADDR_BRT_LO   = 8'h04;
	localparam logic [7:0] ADDR_BRT_HI   = 8'h05;
	localparam logic [7:0] ADDR_AUTO_LO  = 8'h06;
	localparam logic [7:0] ADDR_AUTO_HI  = 8'h07;
	localparam logic [7:0] ADDR_BACKLIGHT_ON_BIT    = 8'h08;
	localparam logic [7:0] ADDR_FLAGS    = 8'h0F;
	localparam logic [7:0] ADDR_OPTION   = 8'h10;

	localparam logic [7:0] RST_CFG1      = 8'h08;
	localparam logic [7:0] RST_CFG2      = 8'h00;
	localparam logic [7:0] RST_BRT_LO    = 8'h07;
	localparam logic [7:0] RST_BRT_HI    = 8'hFF;
	localparam logic [7:0] RST_AUTO      = 8'h00;
	localparam logic [7:0] RST_BACKLIGHT_ON_BIT     = 8'h00;
	localparam logic [7:0] RST_OPTION    = 8'h00;

	localparam int BIT_PWM_EN            = 0;
	localparam int BIT_PWM_RAMP          = 1;
	localparam int BIT_MAP_LINEAR        = 3;
	localparam int BIT_FREQ_SEL          = 7;
	localparam int BIT_BL_ON             = 4;
	localparam int BIT_LOOP_OFF_LSB      = 3;
	localparam int BIT_FLAG_OVP          = 0;
	localparam int BIT_FLAG_OPEN         = 1;
	localparam int BIT_FLAG_WARN         = 2;
	localparam int BIT_FLAG_ACTIVE       = 3;

	// pwm sampling: one sample per period, duty over a 2048-sample window
	localparam int CLK_PERIOD_NS         = 50;
	localparam int SAMPLE_PERIOD_NS      = 1000;
	localparam int SAMPLE_DIV            = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;
	localparam logic [11:0] DUTY_FULL    = 12'h800;

	// currents in units of 10 nA
	localparam logic [21:0] LIN_OFFSET   = 22'h0011B9; // 45.37 uA
	localparam logic [21:0] LIN_SLOPE    = 22'h0005B7; // 14.63 uA
	localparam logic [21:0] EXP_BASE     = 22'h001770; // 60 uA
	// 0.003040572 scaled by 2^26
	localparam logic [17:0] EXP_STEP_K   = 18'h31D11;
	localparam int EXP_FRAC              = 16;
	localparam int EXP_KSHIFT            = 26;

	typedef enum logic [1:0] {
		ST_SHUTDOWN = 2'b00,
		ST_STANDBY  = 2'b01,
		ST_ACTIVE   = 2'b10
	} bl_state_t;

	typedef enum logic [1:0] {
		FREQ_250K = 2'b00,
		FREQ_500K = 2'b01,
		FREQ_1M   = 2'b10
	} boost_freq_t;
endpackage

// ===== hdl/pwm_duty_meter.sv
// measures the duty of the synchronised pwm input over a fixed window
// assumes pwm_i is already in the clk_i domain
`timescale 1ns/1ps
`default_nettype none
module pwm_duty_meter (
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	input  wire logic        clear_i,
	input  wire logic        pwm_i,
	output logic [11:0]      duty_o
);
	logic [7:0]  div_ff;
	logic [10:0] win_ff;
	logic [11:0] high_ff;
	logic        tick;

	assign tick = (div_ff == 8'(bl_pkg::SAMPLE_DIV - 1));

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			div_ff <= 8'h00;
		end else if (clear_i || tick) begin
			div_ff <= 8'h00;
		end else begin
			div_ff <= div_ff + 8'h01;
		end
	end

	// duty is 0..2048 highs per 2048 samples; 2048 means full duty
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			win_ff  <= 11'h000;
			high_ff <= 12'h000;
			duty_o  <= 12'h000;
		end else if (clear_i) begin
			win_ff  <= 11'h000;
			high_ff <= 12'h000;
			duty_o  <= 12'h000;
		end else if (tick) begin
			win_ff <= win_ff + 11'h001;
			if (win_ff == 11'h7FF) begin
				duty_o  <= high_ff + {11'h000, pwm_i};
				high_ff <= 12'h000;
			end else begin
				high_ff <= high_ff + {11'h000, pwm_i};
			end
		end
	end
endmodule // pwm_duty_meter
`default_nettype wire

// ===== hdl/exp_mapper.sv
// exponential law: current = base * ratio^code, by repeated scaling
// assumes start_i pulses with a stable code; result held until next start
`timescale 1ns/1ps
`default_nettype none
module exp_mapper (
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	input  wire logic        start_i,
	input  wire logic [10:0] code_i,
	output logic [21:0]      current_o,
	output logic             busy_o
);
	logic [10:0] cnt_ff;
	logic [37:0] acc_ff;
	logic [55:0] prod;

	// one step per clock: up to 2047 steps plus one cycle to load the result, traded for no lookup table
	assign prod = {18'h00000, acc_ff} * {38'h0, bl_pkg::EXP_STEP_K};

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_ff    <= 11'h000;
			acc_ff    <= 38'h0;
			current_o <= 22'h000000;
			busy_o    <= 1'b0;
		end else if (start_i) begin
			cnt_ff <= code_i;
			acc_ff <= {bl_pkg::EXP_BASE, 16'h0000};
			busy_o <= (code_i != 11'h000);
			if (code_i == 11'h000) begin
				current_o <= 22'h000000;
			end
		end else if (busy_o) begin
			if (cnt_ff == 11'h000) begin
				current_o <= acc_ff[37:bl_pkg::EXP_FRAC];
				busy_o    <= 1'b0;
			end else begin
				acc_ff <= acc_ff + {8'h00, prod[55:bl_pkg::EXP_KSHIFT]};
				cnt_ff <= cnt_ff - 11'h001;
			end
		end
	end
endmodule // exp_mapper
`default_nettype wire

// ===== hdl/backlight_brightness_control.sv
// backlight brightness control: registers, operating state, code, mapping
// assumes an i2c target on clk_i gives write/read strobes; pins are async
`timescale 1ns/1ps
`default_nettype none
module backlight_brightness_control (
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	input  wire logic        master_enable_n_i,
	input  wire logic        pwm_i,
	input  wire logic        wr_en_i,
	input  wire logic [7:0]  wr_addr_i,
	input  wire logic [7:0]  wr_data_i,
	input  wire logic        rd_en_i,
	input  wire logic [7:0]  rd_addr_i,
	input  wire logic        ovp_fault_i,
	input  wire logic        open_fault_i,
	input  wire logic        thermal_warn_i,
	output logic [7:0]       rd_data_o,
	output logic [1:0]       state_o,
	output logic             boost_on_o,
	output logic [1:0]       string_sink_enables_o,
	output logic [1:0]       boost_freq_select_o,
	output logic [10:0]      led_code_o,
	output logic [21:0]      led_current_o
);
	logic [1:0]  en_sync_ff;
	logic [1:0]  pwm_sync_ff;
	logic [2:0]  ovp_sync_ff;
	logic [2:0]  open_sync_ff;
	logic [2:0]  warn_sync_ff;
	logic        enabled;

	logic [7:0]  cfg1_ff;
	logic [7:0]  cfg2_ff;
	logic [2:0]  brt_lo_ff;
	logic [7:0]  brt_hi_ff;
	logic [7:0]  auto_lo_ff;
	logic [7:0]  auto_hi_ff;
	logic [7:0]  backlight_on_bit_ff;
	logic [7:0]  option_ff;
	logic [10:0] brt_code_ff;
	logic [2:0]  flags_ff;

	logic [11:0] duty;
	logic [10:0] ramp_ff;
	logic [10:0] code_ff;
	logic [10:0] nxt_code;
	logic        exp_start_ff;
	logic [21:0] exp_current;
	logic        exp_busy;
	logic        pwm_en;
	logic        map_linear;
	logic        active;
	bl_pkg::bl_state_t state_ff;
	bl_pkg::bl_state_t nxt_state;

	function automatic logic [10:0] scale_by_duty(
		input logic [10:0] code,
		input logic [11:0] d
	);
		logic [22:0] p;
		p = {12'h000, code} * {11'h000, d};
		scale_by_duty = p[21:11];
	endfunction

	function automatic logic wr_hit(input logic [7:0] a);
		wr_hit = wr_en_i && (wr_addr_i == a);
	endfunction

	// pin inputs pass two flops before use
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			en_sync_ff  <= 2'b00;
			pwm_sync_ff <= 2'b00;
		end else begin
			en_sync_ff  <= {en_sync_ff[0], master_enable_n_i};
			pwm_sync_ff <= {pwm_sync_ff[0], pwm_i};
		end
	end

	// bit 2 of each fault chain is a delay stage for edge-free sticky set
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ovp_sync_ff  <= 3'b000;
			open_sync_ff <= 3'b000;
			warn_sync_ff <= 3'b000;
		end else begin
			ovp_sync_ff  <= {ovp_sync_ff[1:0], ovp_fault_i};
			open_sync_ff <= {open_sync_ff[1:0], open_fault_i};
			warn_sync_ff <= {warn_sync_ff[1:0], thermal_warn_i};
		end
	end

	// pin high enables the device; low holds everything in reset
	assign enabled = en_sync_ff[1];

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cfg1_ff    <= bl_pkg::RST_CFG1;
			cfg2_ff    <= bl_pkg::RST_CFG2;
			brt_lo_ff  <= bl_pkg::RST_BRT_LO[2:0];
			brt_hi_ff  <= bl_pkg::RST_BRT_HI;
			auto_lo_ff <= bl_pkg::RST_AUTO;
			auto_hi_ff <= bl_pkg::RST_AUTO;
			backlight_on_bit_ff   <= bl_pkg::RST_BACKLIGHT_ON_BIT;
			option_ff  <= bl_pkg::RST_OPTION;
		end else if (!enabled) begin
			cfg1_ff    <= bl_pkg::RST_CFG1;
			cfg2_ff    <= bl_pkg::RST_CFG2;
			brt_lo_ff  <= bl_pkg::RST_BRT_LO[2:0];
			brt_hi_ff  <= bl_pkg::RST_BRT_HI;
			auto_lo_ff <= bl_pkg::RST_AUTO;
			auto_hi_ff <= bl_pkg::RST_AUTO;
			backlight_on_bit_ff   <= bl_pkg::RST_BACKLIGHT_ON_BIT;
			option_ff  <= bl_pkg::RST_OPTION;
		end else begin
			// writes land in standby as well as active
			if (wr_hit(bl_pkg::ADDR_CFG1)) cfg1_ff <= wr_data_i;
			if (wr_hit(bl_pkg::ADDR_CFG2)) cfg2_ff <= wr_data_i;
			if (wr_hit(bl_pkg::ADDR_BRT_LO)) brt_lo_ff <= wr_data_i[2:0];
			if (wr_hit(bl_pkg::ADDR_BRT_HI)) brt_hi_ff <= wr_data_i;
			if (wr_hit(bl_pkg::ADDR_AUTO_LO)) auto_lo_ff <= wr_data_i;
			if (wr_hit(bl_pkg::ADDR_AUTO_HI)) auto_hi_ff <= wr_data_i;
			if (wr_hit(bl_pkg::ADDR_BACKLIGHT_ON_BIT)) backlight_on_bit_ff <= wr_data_i;
			if (wr_hit(bl_pkg::ADDR_OPTION)) option_ff <= wr_data_i;
		end
	end

	// the applied code only moves when the upper byte is written
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			brt_code_ff <= {bl_pkg::RST_BRT_HI, bl_pkg::RST_BRT_LO[2:0]};
		end else if (!enabled) begin
			brt_code_ff <= {bl_pkg::RST_BRT_HI, bl_pkg::RST_BRT_LO[2:0]};
		end else if (wr_hit(bl_pkg::ADDR_BRT_HI)) begin
			brt_code_ff <= {wr_data_i, brt_lo_ff};
		end
	end

	// sticky faults; a new fault beats the clear-on-read in the same cycle
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			flags_ff <= 3'b000;
		end else if (!enabled) begin
			flags_ff <= 3'b000;
		end else begin
			if (rd_en_i && rd_addr_i == bl_pkg::ADDR_FLAGS) begin
				flags_ff <= {warn_sync_ff[2], open_sync_ff[2],
					ovp_sync_ff[2]};
			end else begin
				flags_ff <= flags_ff | {warn_sync_ff[2], open_sync_ff[2],
					ovp_sync_ff[2]};
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rd_data_o <= 8'h00;
		end else if (!enabled) begin
			rd_data_o <= 8'h00;
		end else if (rd_en_i) begin
			case (rd_addr_i)
				bl_pkg::ADDR_CFG1:    rd_data_o <= cfg1_ff;
				bl_pkg::ADDR_CFG2:    rd_data_o <= cfg2_ff;
				bl_pkg::ADDR_BRT_LO:  rd_data_o <= {5'h00, brt_lo_ff};
				bl_pkg::ADDR_BRT_HI:  rd_data_o <= brt_hi_ff;
				bl_pkg::ADDR_AUTO_LO: rd_data_o <= auto_lo_ff;
				bl_pkg::ADDR_AUTO_HI: rd_data_o <= auto_hi_ff;
				bl_pkg::ADDR_BACKLIGHT_ON_BIT:   rd_data_o <= backlight_on_bit_ff;
				bl_pkg::ADDR_OPTION:  rd_data_o <= option_ff;
				bl_pkg::ADDR_FLAGS: begin
					rd_data_o <= {4'h0, state_ff == bl_pkg::ST_ACTIVE,
						flags_ff};
				end
				default: rd_data_o <= 8'h00;
			endcase
		end
	end

	assign pwm_en     = cfg1_ff[bl_pkg::BIT_PWM_EN];
	assign map_linear = cfg1_ff[bl_pkg::BIT_MAP_LINEAR];

	pwm_duty_meter u_duty (
		.clk_i   (clk_i),
		.rst_n_i (rst_n_i),
		.clear_i (!enabled || !pwm_en),
		.pwm_i   (pwm_sync_ff[1]),
		.duty_o  (duty)
	);

	// ramper stage: ramp timing is outside this block, so it follows at
	// once; the ramp bit still chooses what enters it
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ramp_ff <= 11'h000;
		end else if (pwm_en && cfg1_ff[bl_pkg::BIT_PWM_RAMP]) begin
			ramp_ff <= scale_by_duty(brt_code_ff, duty);
		end else begin
			ramp_ff <= brt_code_ff;
		end
	end

	always_comb begin
		if (!pwm_en) begin
			nxt_code = ramp_ff;
		end else if (cfg1_ff[bl_pkg::BIT_PWM_RAMP]) begin
			nxt_code = ramp_ff;
		end else begin
			nxt_code = scale_by_duty(ramp_ff, duty);
		end
	end

	// the host sequence of strings, brightness then enable is not assumed
	assign active = backlight_on_bit_ff[bl_pkg::BIT_BL_ON]
		&& (brt_code_ff != 11'h000)
		&& (backlight_on_bit_ff[1:0] != 2'b00)
		&& (!pwm_en || duty != 12'h000);

	always_comb begin
		case (state_ff)
			bl_pkg::ST_SHUTDOWN: nxt_state = enabled ?
				bl_pkg::ST_STANDBY : bl_pkg::ST_SHUTDOWN;
			bl_pkg::ST_STANDBY, bl_pkg::ST_ACTIVE: begin
				if (!enabled) begin
					nxt_state = bl_pkg::ST_SHUTDOWN;
				end else if (active) begin
					nxt_state = bl_pkg::ST_ACTIVE;
				end else begin
					nxt_state = bl_pkg::ST_STANDBY;
				end
			end
			default: nxt_state = bl_pkg::ST_SHUTDOWN;
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_ff <= bl_pkg::ST_SHUTDOWN;
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign state_o = state_ff;

	// power stage outputs follow the next state so they agree with it
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			boost_on_o            <= 1'b0;
			string_sink_enables_o <= 2'b00;
		end else if (nxt_state == bl_pkg::ST_ACTIVE) begin
			boost_on_o <= (option_ff[bl_pkg::BIT_LOOP_OFF_LSB +: 2]
				!= 2'b11);
			string_sink_enables_o <= backlight_on_bit_ff[1:0];
		end else begin
			boost_on_o            <= 1'b0;
			string_sink_enables_o <= 2'b00;
		end
	end

	// auto mode whenever either threshold is non-zero
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			boost_freq_select_o <= bl_pkg::FREQ_500K;
		end else if (auto_lo_ff != 8'h00 || auto_hi_ff != 8'h00) begin
			if (brt_hi_ff >= auto_hi_ff) begin
				boost_freq_select_o <= bl_pkg::FREQ_1M;
			end else if (brt_hi_ff < auto_lo_ff) begin
				boost_freq_select_o <= bl_pkg::FREQ_250K;
			end else begin
				boost_freq_select_o <= bl_pkg::FREQ_500K;
			end
		end else if (cfg2_ff[bl_pkg::BIT_FREQ_SEL]) begin
			boost_freq_select_o <= bl_pkg::FREQ_1M;
		end else begin
			boost_freq_select_o <= bl_pkg::FREQ_500K;
		end
	end

	// the mapped code is zero whenever the strings are not driven
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			code_ff      <= 11'h000;
			exp_start_ff <= 1'b0;
		end else begin
			code_ff <= (nxt_state == bl_pkg::ST_ACTIVE) ? nxt_code : 11'h000;
			exp_start_ff <= (((nxt_state == bl_pkg::ST_ACTIVE) ?
				nxt_code : 11'h000) != code_ff) || exp_start_ff && exp_busy;
		end
	end

	exp_mapper u_exp (
		.clk_i     (clk_i),
		.rst_n_i   (rst_n_i),
		.start_i   (exp_start_ff && !exp_busy),
		.code_i    (code_ff),
		.current_o (exp_current),
		.busy_o    (exp_busy)
	);

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			led_code_o    <= 11'h000;
			led_current_o <= 22'h000000;
		end else begin
			led_code_o <= code_ff;
			if (code_ff == 11'h000) begin
				led_current_o <= 22'h000000;
			end else if (map_linear) begin
				led_current_o <= bl_pkg::LIN_OFFSET
					+ 22'(bl_pkg::LIN_SLOPE * {11'h000, code_ff});
			end else if (!exp_busy && !exp_start_ff) begin
				led_current_o <= exp_current;
			end
		end
	end
endmodule // backlight_brightness_control
`default_nettype wire

// ===== sim/pwm_source.sv
// pwm source for the far side: a steady low, or a square wave at half duty
// assumes the block samples pwm_i once every 20 clocks
`timescale 1ns/1ps
`default_nettype none
module pwm_source (
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	input  wire logic en_i,
	output logic      pwm_o
);
	logic [5:0] phase_ff;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			phase_ff <= 6'h00;
		end else begin
			phase_ff <= (phase_ff == 6'h27) ? 6'h00 : phase_ff + 6'h01;
		end
	end

	// a period of two sample slots, so any window sees exactly half high
	assign pwm_o = en_i && (phase_ff < 6'h14);
endmodule // pwm_source
`default_nettype wire

// ===== sim/backlight_brightness_control_asserts.sv
// port checker for the backlight brightness control block
// assumes it is bound onto the top module with one clock domain
`timescale 1ns/1ps
`default_nettype none
module backlight_brightness_control_asserts (
	input wire logic        clk_i,
	input wire logic        rst_n_i,
	input wire logic        master_enable_n_i,
	input wire logic        rd_en_i,
	input wire logic [7:0]  rd_data_o,
	input wire logic [1:0]  state_o,
	input wire logic        boost_on_o,
	input wire logic [1:0]  string_sink_enables_o,
	input wire logic [1:0]  boost_freq_select_o,
	input wire logic [10:0] led_code_o,
	input wire logic [21:0] led_current_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	a_pin_low_off: assert property ((!master_enable_n_i)[*4]
		|-> state_o == 2'h0) else $error("not shut down");
	a_off_reads_zero: assert property ((!master_enable_n_i)[*4]
		##0 rd_en_i |=> rd_data_o == 8'h00) else $error("read not zero");
	a_reset_quiet: assert property ($rose(rst_n_i) |-> state_o == 2'h0
		&& led_current_o == 22'h0 && string_sink_enables_o == 2'h0)
		else $error("outputs busy after reset");
	a_pin_high_wakes: assert property (master_enable_n_i[*5]
		|-> state_o != 2'h0) else $error("still shut down");
	a_boost_needs_act: assert property (boost_on_o |-> state_o == 2'h2
		&& string_sink_enables_o != 2'h0) else $error("boost on while idle");
	a_idle_sinks_off: assert property ((state_o != 2'h2)[*2] |->
		string_sink_enables_o == 2'h0 && led_code_o == 11'h0)
		else $error("sinks on while idle");
	a_zero_code_dark: assert property ((led_code_o == 11'h0)[*8] |->
		led_current_o == 22'h0) else $error("current without code");
	a_freq_legal: assert property (boost_freq_select_o != 2'h3)
		else $error("bad frequency select");
	a_read_holds: assert property (master_enable_n_i[*4] ##0 !rd_en_i
		|=> $stable(rd_data_o)) else $error("read data moved");
endmodule // backlight_brightness_control_asserts
`default_nettype wire

// ===== sim/backlight_brightness_control_tb.sv
// self-checking bench for the backlight brightness control block
// assumes the partner pwm source and the bound port checker
`timescale 1ns/1ps
`default_nettype none
module backlight_brightness_control_tb;
	localparam logic [7:0] RA [8] = '{8'h02, 8'h03, 8'h04, 8'h05, 8'h06,
		8'h08, 8'h10, 8'h01};
	localparam logic [7:0] RV [8] = '{8'h08, 8'h00, 8'h07, 8'hFF, 8'h00,
		8'h00, 8'h00, 8'h00};
	localparam logic [10:0] EC [4] = '{11'h001, 11'h400, 11'h7FF, 11'h000};
	localparam logic [7:0] FB [5] = '{8'h20, 8'h40, 8'h60, 8'h80, 8'hFF};
	localparam logic [1:0] FQ [5] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h2};
	logic        clk_i = 1'b0;
	logic        rst_n_i = 1'b0;
	logic        master_enable_n_i = 1'b1;
	logic        wr_en_i = 1'b0;
	logic        rd_en_i = 1'b0;
	logic [7:0]  wr_addr_i = 8'h00;
	logic [7:0]  wr_data_i = 8'h00;
	logic [7:0]  rd_addr_i = 8'h00;
	logic [2:0]  fault = 3'h0;
	logic        pwm_en = 1'b0;
	logic        pwm;
	logic [7:0]  rd_data_o;
	logic [1:0]  state_o;
	logic [1:0]  boost_freq_select_o;
	logic [1:0]  string_sink_enables_o;
	logic        boost_on_o;
	logic [10:0] led_code_o;
	logic [21:0] led_current_o;
	int          err_total = 0;
	int          n_compared = 0;

	initial forever #25 clk_i = ~clk_i;

	backlight_brightness_control backlight_brightness_control_inst (
		.clk_i, .rst_n_i, .master_enable_n_i, .pwm_i(pwm), .wr_en_i,
		.wr_addr_i, .wr_data_i, .rd_en_i, .rd_addr_i,
		.ovp_fault_i(fault[0]), .open_fault_i(fault[1]),
		.thermal_warn_i(fault[2]), .rd_data_o, .state_o, .boost_on_o,
		.string_sink_enables_o, .boost_freq_select_o, .led_code_o,
		.led_current_o);

	pwm_source pwm_source_inst (.clk_i, .rst_n_i, .en_i(pwm_en), .pwm_o(pwm));

	task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value at %0t: %0h vs %0h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		wr_en_i <= 1'b1;
		wr_addr_i <= a;
		wr_data_i <= d;
		@(posedge clk_i);
		wr_en_i <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_i);
		rd_en_i <= 1'b1;
		rd_addr_i <= a;
		@(posedge clk_i);
		rd_en_i <= 1'b0;
		#1 d = rd_data_o;
	endtask

	// low bits first: the code only moves on the upper write
	task automatic set_code(input logic [10:0] c);
		wr(8'h04, {5'h00, c[2:0]});
		wr(8'h05, c[10:3]);
	endtask

	task automatic settle(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask

	function automatic logic [10:0] want_code(input logic [1:0] s,
		input logic [10:0] c);
		return (s != 2'h0 && c != 11'h000) ? c : 11'h000;
	endfunction

	function automatic logic [21:0] lin(input logic [10:0] c);
		return (c == 11'h000) ? 22'h0
			: bl_pkg::LIN_OFFSET + bl_pkg::LIN_SLOPE * c;
	endfunction

	task automatic results();
		if (err_total == 0 && n_compared > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	initial begin
		repeat (90000) @(posedge clk_i);
		err_total++;
		results();
	end

	initial begin
		logic [7:0]  d;
		logic [1:0]  s;
		logic [10:0] code;
		logic [10:0] applied;
		logic        act;
		real         want;
		void'($urandom(75));
		applied = 11'h7FF;
		repeat (16) @(posedge clk_i);
		rst_n_i <= 1'b1;
		settle(4);
		foreach (RA[i]) begin
			rd(RA[i], d);
			chk(d, RV[i]);
		end
		wr(8'h08, 8'h13);
		settle(6);
		chk(led_current_o, lin(11'h7FF));
		for (int i = 0; i < 10; i++) begin
			code = (i < 2) ? 11'(i) : 11'($urandom_range(2047));
			s = (i == 2) ? 2'h0 : 2'($urandom_range(3, 1));
			wr(8'h08, {6'h04, s});
			wr(8'h04, {5'h00, code[2:0]});
			settle(6);
			chk(led_code_o, want_code(s, applied));
			wr(8'h05, code[10:3]);
			applied = code;
			settle(6);
			act = (want_code(s, code) != 11'h000);
			chk(led_code_o, want_code(s, code));
			chk(state_o, act ? 2'h2 : 2'h1);
			chk(string_sink_enables_o, act ? s : 2'h0);
			chk(boost_on_o, act);
			chk(led_current_o, lin(want_code(s, code)));
		end
		set_code(11'h5A3);
		wr(8'h08, 8'h13);
		wr(8'h10, 8'h18);
		settle(6);
		chk({boost_on_o, string_sink_enables_o, state_o}, 5'h0E);
		wr(8'h10, 8'h08);
		settle(6);
		chk(boost_on_o, 1'b1);
		wr(8'h10, 8'h00);
		wr(8'h02, 8'h00);
		foreach (EC[i]) begin
			set_code(EC[i]);
			settle(2100);
			want = (EC[i] == 0) ? 0.0 : 6000.0 * (1.003040572 ** EC[i]);
			chk(led_current_o >= want * 0.995 && led_current_o <= want * 1.005,
				1'b1);
		end
		wr(8'h02, 8'h08);
		settle(2);
		chk(boost_freq_select_o, 2'h1);
		wr(8'h03, 8'h80);
		settle(4);
		chk(boost_freq_select_o, 2'h2);
		wr(8'h06, 8'h40);
		wr(8'h07, 8'h80);
		foreach (FB[i]) begin
			set_code({FB[i], 3'h0});
			settle(6);
			chk(boost_freq_select_o, FQ[i]);
		end
		@(posedge clk_i) fault <= 3'h7;
		repeat (5) @(posedge clk_i);
		fault <= 3'h0;
		// let the fault pipeline drain so the clear-on-read sticks
		settle(4);
		rd(8'h0F, d);
		chk(d, 8'h0F);
		rd(8'h0F, d);
		chk(d, 8'h08);
		wr(8'h08, 8'h03);
		settle(6);
		chk({boost_on_o, string_sink_enables_o, state_o}, 5'h01);
		rd(8'h05, d);
		chk(d, 8'hFF);
		wr(8'h08, 8'h13);
		set_code(11'h5A3);
		pwm_en <= 1'b1;
		wr(8'h02, 8'h09);
		settle(10);
		chk(state_o, 2'h1);
		for (int n = 0; n < 50000 && state_o !== 2'h2; n++) @(posedge clk_i);
		settle(6);
		chk(state_o, 2'h2);
		// half duty halves the code, odd codes round down
		chk(led_code_o, 11'h2D1);
		wr(8'h02, 8'h0B);
		settle(6);
		chk(led_current_o, lin(11'h2D1));
		@(posedge clk_i) master_enable_n_i <= 1'b0;
		settle(5);
		chk({state_o, led_current_o}, 24'h0);
		wr(8'h02, 8'h00);
		rd(8'h05, d);
		chk(d, 8'h00);
		@(posedge clk_i) master_enable_n_i <= 1'b1;
		settle(5);
		chk(state_o, 2'h1);
		rd(8'h02, d);
		chk(d, 8'h08);
		rd(8'h05, d);
		chk(d, 8'hFF);
		results();
	end
endmodule // backlight_brightness_control_tb

bind backlight_brightness_control backlight_brightness_control_asserts
	chk_inst (.clk_i, .rst_n_i, .master_enable_n_i, .rd_en_i, .rd_data_o,
	.state_o, .boost_on_o, .string_sink_enables_o, .boost_freq_select_o,
	.led_code_o, .led_current_o);
`default_nettype wire
